// File: hdl/hub_cfg_pkg.sv
package hub_cfg_pkg;
    // Register offsets
    localparam logic [7:0] OFS_BP_PORT_DISABLE   = 8'h0b;
    localparam logic [7:0] OFS_SP_MAX_POWER      = 8'h0c;
    localparam logic [7:0] OFS_BP_MAX_POWER      = 8'h0d;
    localparam logic [7:0] OFS_SP_CTRL_CURRENT   = 8'h0e;
    localparam logic [7:0] OFS_BP_CTRL_CURRENT   = 8'h0f;
    localparam logic [7:0] OFS_POWER_GOOD_DELAY  = 8'h10;
    localparam logic [7:0] OFS_LANGUAGE_UPPER    = 8'h11;
    localparam logic [7:0] OFS_LANGUAGE_LOWER    = 8'h12;
    localparam logic [7:0] OFS_MAKER_STR_LEN     = 8'h13;
    // Reset values
    localparam logic [7:0] RST_CTRL_CURRENT      = 8'h32;
    localparam logic [7:0] RST_ZERO              = 8'h00;
    // Port disable mask layout
    localparam logic [7:0] PORT_MASK_VALID       = 8'h1e;
    localparam int         PORT_FIELD_LSB        = 1;
    localparam int         NUM_PORTS             = 4;
    // String length ceiling
    localparam logic [7:0] MAX_STRING_CHARS      = 8'h1f;
    // Timing: units of the delay byte, in ms, and clock rate in kHz
    localparam int         POWER_UNIT_MS         = 2;
    localparam int         CLOCK_KHZ             = 125000;
    localparam int         CYCLES_PER_UNIT       = POWER_UNIT_MS * CLOCK_KHZ;
endpackage : hub_cfg_pkg

// File: hdl/port_renumber.sv
`timescale 1ns/1ps
module port_renumber #(
    parameter int PORTS = 4
) (
    // Disable mask, one bit per port, port 1 in bit 0
    input  wire logic [PORTS-1:0]   disabled_in,
    // Logical to physical map, 3 bits per logical port
    output logic [3*PORTS-1:0]      map_out,
    output logic [2:0]              count_out
);
    initial begin
        if (PORTS < 1 || PORTS > 7) begin
            $error("port_renumber: PORTS out of range");
        end
    end

    // Packs enabled physical ports into logical slots in ascending order
    always_comb begin
        logic [2:0] slot;
        slot    = 3'h0;
        map_out = '0;
        for (int p = 0; p < PORTS; p++) begin
            if (!disabled_in[p]) begin
                map_out[3*slot +: 3] = 3'(p + 1);
                slot = slot + 3'h1;
            end
        end
        count_out = slot;
    end
endmodule : port_renumber

// File: hdl/power_good_timer.sv
`timescale 1ns/1ps
module power_good_timer #(
    parameter int UNIT_CYCLES = hub_cfg_pkg::CYCLES_PER_UNIT
) (
    input  wire logic       clk_in,
    input  wire logic       rst_n_in,
    // Start pulse and delay in units
    input  wire logic       start_in,
    input  wire logic [7:0] units_in,
    output logic            good_out
);
    initial begin
        if (UNIT_CYCLES < 1) begin
            $error("power_good_timer: UNIT_CYCLES must be positive");
        end
    end

    typedef struct packed {
        logic [31:0] tick;
        logic [7:0]  left;
        logic        busy;
        logic        good;
    } timer_state_type;

    timer_state_type st;
    timer_state_type next_st;

    // Power good after units_in whole units; zero gives good next cycle
    always_comb begin
        next_st = st;
        if (start_in) begin
            next_st.tick = 32'h0;
            next_st.left = units_in;
            next_st.busy = (units_in != 8'h00);
            next_st.good = (units_in == 8'h00);
        end else if (st.busy) begin
            if (st.tick == 32'(UNIT_CYCLES - 1)) begin
                next_st.tick = 32'h0;
                next_st.left = st.left - 8'h01;
                if (st.left == 8'h01) begin
                    next_st.busy = 1'b0;
                    next_st.good = 1'b1;
                end
            end else begin
                next_st.tick = st.tick + 32'h1;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign good_out = st.good;
endmodule : power_good_timer

// File: hdl/hub_port_power_config_regs.sv
`timescale 1ns/1ps
module hub_port_power_config_regs #(
    parameter int PORTS       = hub_cfg_pkg::NUM_PORTS,
    parameter int UNIT_CYCLES = hub_cfg_pkg::CYCLES_PER_UNIT
) (
    // Clock and reset
    input  wire logic                 CLOCK_IN,
    input  wire logic                 RESETN_IN,
    // Configuration loader port
    input  wire logic                 CFG_WRITE_IN,
    input  wire logic                 CFG_READ_IN,
    input  wire logic [7:0]           CFG_ADDR_IN,
    input  wire logic [7:0]           CFG_WDATA_IN,
    output logic [7:0]                CFG_RDATA_OUT,
    output logic                      CFG_HIT_OUT,
    // Operating mode
    input  wire logic                 BUS_POWERED_IN,
    input  wire logic                 PORT_REMAP_ENABLE_IN,
    input  wire logic                 INTERNAL_DEFAULT_IN,
    input  wire logic [1:0]           PORT_DISABLE_STRAPS_IN,
    // Host port power requests
    input  wire logic [PORTS-1:0]     PORT_POWER_REQ_IN,
    input  wire logic [PORTS-1:0]     PORT_ENABLE_REQ_IN,
    // Effective configuration
    output logic [PORTS-1:0]          PORT_DISABLED_OUT,
    output logic [PORTS-1:0]          PORT_ENABLED_OUT,
    output logic [2:0]                PORT_COUNT_OUT,
    output logic [3*PORTS-1:0]        PORT_MAP_OUT,
    output logic [7:0]                MAX_POWER_OUT,
    output logic [7:0]                CONTROLLER_CURRENT_OUT,
    output logic [15:0]               LANGUAGE_ID_OUT,
    output logic [7:0]                MAKER_STRING_LENGTH_OUT,
    output logic [PORTS-1:0]          PORT_POWER_GOOD_OUT
);
    initial begin
        if (PORTS != 4) begin
            $error("hub_port_power_config_regs: only 4 ports supported");
        end
    end

    typedef struct packed {
        logic [7:0]       bp_disable;
        logic [7:0]       sp_max_power;
        logic [7:0]       bp_max_power;
        logic [7:0]       sp_ctrl_current;
        logic [7:0]       bp_ctrl_current;
        logic [7:0]       power_delay;
        logic [7:0]       lang_upper;
        logic [7:0]       lang_lower;
        logic [7:0]       maker_len;
        logic [7:0]       rdata;
        logic             hit;
        logic [PORTS-1:0] disabled;
        logic [PORTS-1:0] enabled;
        logic [7:0]       max_power;
        logic [7:0]       ctrl_current;
        logic [15:0]      language;
        logic [PORTS-1:0] power_req_d;
    } regs_state_type;

    regs_state_type st;
    regs_state_type next_st;

    logic [PORTS-1:0]   strap_mask;
    logic [PORTS-1:0]   eff_disabled;
    logic [PORTS-1:0]   power_start;
    logic [2:0]         count;
    logic [3*PORTS-1:0] map;

    // Straps encode how many top ports are off, as in a reduced-port SKU
    always_comb begin
        case (PORT_DISABLE_STRAPS_IN)
            2'b01:   strap_mask = 4'b1000;
            2'b10:   strap_mask = 4'b1100;
            2'b11:   strap_mask = 4'b1110;
            default: strap_mask = 4'b0000;
        endcase
    end

    // Remap on leaves the port set to the remap tables, not this mask, unless INTERNAL_DEFAULT_IN selects the strap mask
    always_comb begin
        if (INTERNAL_DEFAULT_IN) begin
            eff_disabled = strap_mask;
        end else if (!BUS_POWERED_IN || PORT_REMAP_ENABLE_IN) begin
            eff_disabled = '0;
        end else begin
            eff_disabled = st.bp_disable[PORTS:1];
        end
    end

    port_renumber #(
        .PORTS       (PORTS)
    ) u_renumber (
        .disabled_in (st.disabled),
        .map_out     (map),
        .count_out   (count)
    );

    always_comb begin
        next_st = st;
        next_st.disabled    = eff_disabled;
        // Host cannot enable a disabled port
        next_st.enabled     = PORT_ENABLE_REQ_IN & ~eff_disabled;
        next_st.max_power   = BUS_POWERED_IN ?
                              st.bp_max_power :
                              st.sp_max_power;
        next_st.ctrl_current = BUS_POWERED_IN ?
                               st.bp_ctrl_current :
                               st.sp_ctrl_current;
        next_st.language    = {st.lang_upper, st.lang_lower};
        next_st.power_req_d = PORT_POWER_REQ_IN & ~eff_disabled;
        next_st.hit         = 1'b0;
        if (CFG_WRITE_IN) begin
            case (CFG_ADDR_IN)
                hub_cfg_pkg::OFS_BP_PORT_DISABLE:
                    next_st.bp_disable = CFG_WDATA_IN
                                       & hub_cfg_pkg::PORT_MASK_VALID;
                hub_cfg_pkg::OFS_SP_MAX_POWER:
                    next_st.sp_max_power = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_BP_MAX_POWER:
                    next_st.bp_max_power = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_SP_CTRL_CURRENT:
                    next_st.sp_ctrl_current = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_BP_CTRL_CURRENT:
                    next_st.bp_ctrl_current = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_POWER_GOOD_DELAY:
                    next_st.power_delay = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_LANGUAGE_UPPER:
                    next_st.lang_upper = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_LANGUAGE_LOWER:
                    next_st.lang_lower = CFG_WDATA_IN;
                hub_cfg_pkg::OFS_MAKER_STR_LEN:
                    // Overlong count clamps so the descriptor never overruns
                    next_st.maker_len = (CFG_WDATA_IN >
                                         hub_cfg_pkg::MAX_STRING_CHARS) ?
                                        hub_cfg_pkg::MAX_STRING_CHARS :
                                        CFG_WDATA_IN;
                default: ;
            endcase
        end
        if (CFG_READ_IN) begin
            next_st.hit = 1'b1;
            case (CFG_ADDR_IN)
                hub_cfg_pkg::OFS_BP_PORT_DISABLE:
                    next_st.rdata = st.bp_disable;
                hub_cfg_pkg::OFS_SP_MAX_POWER:
                    next_st.rdata = st.sp_max_power;
                hub_cfg_pkg::OFS_BP_MAX_POWER:
                    next_st.rdata = st.bp_max_power;
                hub_cfg_pkg::OFS_SP_CTRL_CURRENT:
                    next_st.rdata = st.sp_ctrl_current;
                hub_cfg_pkg::OFS_BP_CTRL_CURRENT:
                    next_st.rdata = st.bp_ctrl_current;
                hub_cfg_pkg::OFS_POWER_GOOD_DELAY:
                    next_st.rdata = st.power_delay;
                hub_cfg_pkg::OFS_LANGUAGE_UPPER:
                    next_st.rdata = st.lang_upper;
                hub_cfg_pkg::OFS_LANGUAGE_LOWER:
                    next_st.rdata = st.lang_lower;
                hub_cfg_pkg::OFS_MAKER_STR_LEN:
                    next_st.rdata = st.maker_len;
                default: begin
                    next_st.rdata = hub_cfg_pkg::RST_ZERO;
                    next_st.hit   = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLOCK_IN) begin
        if (!RESETN_IN) begin
            st                 <= '0;
            st.sp_ctrl_current <= hub_cfg_pkg::RST_CTRL_CURRENT;
            st.bp_ctrl_current <= hub_cfg_pkg::RST_CTRL_CURRENT;
        end else begin
            st <= next_st;
        end
    end

    // A new rising request restarts that port's power-good timer
    assign power_start = next_st.power_req_d & ~st.power_req_d;

    genvar g;
    generate
        for (g = 0; g < PORTS; g++) begin : g_port
            logic good;
            power_good_timer #(
                .UNIT_CYCLES (UNIT_CYCLES)
            ) u_timer (
                .clk_in      (CLOCK_IN),
                .rst_n_in    (RESETN_IN),
                .start_in    (power_start[g]),
                .units_in    (st.power_delay),
                .good_out    (good)
            );
            assign PORT_POWER_GOOD_OUT[g] = good & st.power_req_d[g];
        end
    endgenerate

    assign CFG_RDATA_OUT           = st.rdata;
    assign CFG_HIT_OUT             = st.hit;
    assign PORT_DISABLED_OUT       = st.disabled;
    assign PORT_ENABLED_OUT        = st.enabled;
    assign PORT_COUNT_OUT          = count;
    assign PORT_MAP_OUT            = map;
    assign MAX_POWER_OUT           = st.max_power;
    assign CONTROLLER_CURRENT_OUT  = st.ctrl_current;
    assign LANGUAGE_ID_OUT         = st.language;
    assign MAKER_STRING_LENGTH_OUT = st.maker_len;

    a_mask_reserved: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (st.bp_disable & ~hub_cfg_pkg::PORT_MASK_VALID) == 8'h00)
        else $error("reserved mask bits set");

    a_read_reserved: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (CFG_READ_IN && CFG_ADDR_IN == hub_cfg_pkg::OFS_BP_PORT_DISABLE)
        |=> CFG_HIT_OUT
            && (CFG_RDATA_OUT & ~hub_cfg_pkg::PORT_MASK_VALID) == 8'h00)
        else $error("reserved mask bits read back");

    a_disabled_blocked: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (PORT_ENABLED_OUT & PORT_DISABLED_OUT) == '0)
        else $error("disabled port enabled");

    a_enable_masked: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        1'b1 |=> PORT_ENABLED_OUT
                 == ($past(PORT_ENABLE_REQ_IN) & ~PORT_DISABLED_OUT))
        else $error("enable request not passed");

    a_remap_clear: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (!INTERNAL_DEFAULT_IN && PORT_REMAP_ENABLE_IN)
        |=> PORT_DISABLED_OUT == '0)
        else $error("mask applied while remapping");

    a_mask_applied: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (!INTERNAL_DEFAULT_IN && BUS_POWERED_IN && !PORT_REMAP_ENABLE_IN)
        |=> PORT_DISABLED_OUT == $past(st.bp_disable[PORTS:1]))
        else $error("mask not applied");

    a_port_count: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        32'(PORT_COUNT_OUT) == PORTS - $countones(PORT_DISABLED_OUT))
        else $error("port count wrong");

    a_map_full: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        PORT_DISABLED_OUT == 4'h0 |-> PORT_MAP_OUT == 12'h8d1)
        else $error("full map wrong");

    a_map_empty: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        PORT_COUNT_OUT == 3'h0 |-> PORT_MAP_OUT == '0)
        else $error("empty map not cleared");

    a_strap_select: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (INTERNAL_DEFAULT_IN && PORT_DISABLE_STRAPS_IN == 2'b11)
        |=> PORT_DISABLED_OUT == 4'b1110)
        else $error("straps ignored");

    a_self_power: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !BUS_POWERED_IN |=> MAX_POWER_OUT == $past(st.sp_max_power))
        else $error("self power value wrong");

    a_power_select: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        BUS_POWERED_IN |=> MAX_POWER_OUT == $past(st.bp_max_power))
        else $error("bus power value wrong");

    a_self_select: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        !BUS_POWERED_IN
        |=> CONTROLLER_CURRENT_OUT == $past(st.sp_ctrl_current))
        else $error("self current wrong");

    a_bus_current: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        BUS_POWERED_IN
        |=> CONTROLLER_CURRENT_OUT == $past(st.bp_ctrl_current))
        else $error("bus current wrong");

    a_current_reset: assert property (
        @(posedge CLOCK_IN)
        $rose(RESETN_IN) |-> st.sp_ctrl_current == 8'h32
                          && st.bp_ctrl_current == 8'h32)
        else $error("current reset wrong");

    a_language: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        ##1 LANGUAGE_ID_OUT == {$past(st.lang_upper), $past(st.lang_lower)})
        else $error("language id wrong");

    a_maker_len: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        MAKER_STRING_LENGTH_OUT <= hub_cfg_pkg::MAX_STRING_CHARS)
        else $error("string length too long");

    a_zero_delay: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        (power_start[0] && st.power_delay == 8'h00 && PORT_POWER_REQ_IN[0]
         && !PORT_DISABLED_OUT[0]) |=> PORT_POWER_GOOD_OUT[0])
        else $error("power good late");

    a_good_needs_req: assert property (
        @(posedge CLOCK_IN) disable iff (!RESETN_IN)
        PORT_POWER_GOOD_OUT[0] |-> $past(PORT_POWER_REQ_IN[0]))
        else $error("power good without request");

    c_bus_powered: cover property (@(posedge CLOCK_IN) BUS_POWERED_IN
        && PORT_DISABLED_OUT != '0);
    c_strap_mode:  cover property (@(posedge CLOCK_IN) INTERNAL_DEFAULT_IN
        && PORT_COUNT_OUT == 3'h1);
    c_power_good:  cover property (@(posedge CLOCK_IN)
        $rose(PORT_POWER_GOOD_OUT[0]));
    c_remap_mode:  cover property (@(posedge CLOCK_IN)
        PORT_REMAP_ENABLE_IN && BUS_POWERED_IN);
    c_len_clamp:   cover property (@(posedge CLOCK_IN)
        MAKER_STRING_LENGTH_OUT == hub_cfg_pkg::MAX_STRING_CHARS);
endmodule : hub_port_power_config_regs

// File: verif/cfg_loader.sv
`timescale 1ns/1ps
module cfg_loader (
    // Clock
    input  wire logic       clk_in,
    // Loader bus
    output logic            write_out,
    output logic            read_out,
    output logic [7:0]      addr_out,
    output logic [7:0]      wdata_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       hit_in
);
    initial begin
        write_out = 1'b0;
        read_out  = 1'b0;
        addr_out  = 8'h5a;
        wdata_out = 8'ha5;
    end

    // Self-powered power bytes capped at 50 units, the 100 mA ceiling
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] v;
        v = d;
        if ((a == hub_cfg_pkg::OFS_SP_MAX_POWER ||
             a == hub_cfg_pkg::OFS_SP_CTRL_CURRENT) && d > 8'h32) begin
            v = 8'h32;
        end
        @(posedge clk_in);
        write_out <= 1'b1;
        addr_out  <= a;
        wdata_out <= v;
        @(posedge clk_in);
        write_out <= 1'b0;
        // Released lines must not keep showing the last byte
        addr_out  <= ~a;
        wdata_out <= ~v;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d,
                      output logic h);
        @(posedge clk_in);
        read_out <= 1'b1;
        addr_out <= a;
        @(posedge clk_in);
        read_out <= 1'b0;
        addr_out <= ~a;
        #1;
        d = rdata_in;
        h = hit_in;
    endtask : rd
endmodule : cfg_loader

// File: verif/hub_port_power_config_regs_bench.sv
`timescale 1ns/1ps
module hub_port_power_config_regs_bench;
    localparam int UNITS = 4;
    logic        clock = 1'b0;
    logic        resetn = 1'b0;
    logic        bus_powered = 1'b0;
    logic        remap = 1'b0;
    logic        int_default = 1'b0;
    logic [1:0]  straps = 2'h0;
    logic [3:0]  power_req = 4'h0;
    logic [3:0]  enable_req = 4'h0;
    logic        cfg_write, cfg_read, cfg_hit;
    logic [7:0]  cfg_addr, cfg_wdata, cfg_rdata;
    logic [3:0]  disabled, enabled, power_good;
    logic [2:0]  count;
    logic [11:0] port_map;
    logic [7:0]  max_power, ctrl_current, str_len;
    logic [15:0] lang_id;
    int          n_errors = 0;
    int          comparisons = 0;

    always #4 clock = ~clock;

    hub_port_power_config_regs #(.PORTS(4), .UNIT_CYCLES(UNITS)) dut (
        .CLOCK_IN(clock), .RESETN_IN(resetn),
        .CFG_WRITE_IN(cfg_write), .CFG_READ_IN(cfg_read),
        .CFG_ADDR_IN(cfg_addr), .CFG_WDATA_IN(cfg_wdata),
        .CFG_RDATA_OUT(cfg_rdata), .CFG_HIT_OUT(cfg_hit),
        .BUS_POWERED_IN(bus_powered), .PORT_REMAP_ENABLE_IN(remap),
        .INTERNAL_DEFAULT_IN(int_default),
        .PORT_DISABLE_STRAPS_IN(straps),
        .PORT_POWER_REQ_IN(power_req), .PORT_ENABLE_REQ_IN(enable_req),
        .PORT_DISABLED_OUT(disabled), .PORT_ENABLED_OUT(enabled),
        .PORT_COUNT_OUT(count), .PORT_MAP_OUT(port_map),
        .MAX_POWER_OUT(max_power), .CONTROLLER_CURRENT_OUT(ctrl_current),
        .LANGUAGE_ID_OUT(lang_id), .MAKER_STRING_LENGTH_OUT(str_len),
        .PORT_POWER_GOOD_OUT(power_good));

    cfg_loader loader (
        .clk_in(clock), .write_out(cfg_write), .read_out(cfg_read),
        .addr_out(cfg_addr), .wdata_out(cfg_wdata),
        .rdata_in(cfg_rdata), .hit_in(cfg_hit));

    task automatic close_out;
        $display("Counts: %0d comparisons, %0d mismatches",
                 comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : close_out

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] seen);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp,
                          input logic hit_exp);
        logic [7:0] d;
        logic       h;
        loader.rd(a, d, h);
        chk("rdata", {8'h00, exp}, {8'h00, d});
        chk("hit", {15'h0, hit_exp}, {15'h0, h});
    endtask : rd_chk

    // Derived outputs trail the stored value by up to two cycles
    task automatic settle;
        repeat (3) @(posedge clock);
        #1;
    endtask : settle

    task automatic t_reset_values;
        logic [7:0] a;
        for (int i = 11; i <= 19; i++) begin
            a = 8'(i);
            rd_chk(a, (a == 8'h0e || a == 8'h0f) ? 8'h32 : 8'h00,
                   1'b1);
        end
        @(posedge clock);
        #1;
        chk("hit_drop", 16'h0, {15'h0, cfg_hit});
        rd_chk(8'h0a, 8'h00, 1'b0);
        rd_chk(8'h14, 8'h00, 1'b0);
        chk("ctrl_current", 16'h0032, {8'h00, ctrl_current});
        $display("END reset values");
    endtask : t_reset_values

    task automatic t_mask;
        @(posedge clock);
        bus_powered <= 1'b1;
        enable_req  <= 4'hf;
        loader.wr(8'h0b, 8'hff);
        rd_chk(8'h0b, 8'h1e, 1'b1);
        settle();
        chk("disabled_all", 16'h000f, {12'h0, disabled});
        chk("count_none", 16'h0000, {13'h0, count});
        chk("enabled_none", 16'h0000, {12'h0, enabled});
        loader.wr(8'h0b, 8'h0a);
        settle();
        chk("disabled_1_3", 16'h0005, {12'h0, disabled});
        chk("enabled_2_4", 16'h000a, {12'h0, enabled});
        chk("count_two", 16'h0002, {13'h0, count});
        chk("map_2_4", 16'h0022, {4'h0, port_map});
        @(posedge clock);
        remap <= 1'b1;
        settle();
        chk("remap_on", 16'h0000, {12'h0, disabled});
        @(posedge clock);
        remap       <= 1'b0;
        bus_powered <= 1'b0;
        settle();
        chk("self_powered", 16'h0000, {12'h0, disabled});
        $display("END port mask");
    endtask : t_mask

    task automatic t_straps;
        logic [3:0] strap_exp [4] = '{4'h0, 4'h8, 4'hc, 4'he};
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            bus_powered <= 1'b1;
            int_default <= 1'b1;
            straps      <= 2'(i);
            settle();
            chk("strap_mask", {12'h0, strap_exp[i]},
                {12'h0, disabled});
            chk("strap_count", 16'(4 - i), {13'h0, count});
        end
        @(posedge clock);
        int_default <= 1'b0;
        $display("END straps");
    endtask : t_straps

    task automatic t_power;
        loader.wr(8'h0c, 8'h2a);
        loader.wr(8'h0d, 8'h64);
        loader.wr(8'h0e, 8'h19);
        loader.wr(8'h0f, 8'h40);
        @(posedge clock);
        bus_powered <= 1'b0;
        settle();
        chk("sp_max", 16'h002a, {8'h0, max_power});
        chk("sp_ctrl", 16'h0019, {8'h0, ctrl_current});
        @(posedge clock);
        bus_powered <= 1'b1;
        settle();
        chk("bp_max", 16'h0064, {8'h0, max_power});
        chk("bp_ctrl", 16'h0040, {8'h0, ctrl_current});
        loader.wr(8'h0c, 8'h80);
        rd_chk(8'h0c, 8'h32, 1'b1);
        $display("END power values");
    endtask : t_power

    task automatic t_strings;
        logic [7:0] len_in [4]  = '{8'h1f, 8'h20, 8'hff, 8'h05};
        logic [7:0] len_exp [4] = '{8'h1f, 8'h1f, 8'h1f, 8'h05};
        loader.wr(8'h11, 8'h04);
        loader.wr(8'h12, 8'h09);
        settle();
        chk("lang_id", 16'h0409, lang_id);
        for (int i = 0; i < 4; i++) begin
            loader.wr(8'h13, len_in[i]);
            settle();
            chk("str_len", {8'h0, len_exp[i]}, {8'h0, str_len});
        end
        $display("END strings");
    endtask : t_strings

    task automatic t_power_good;
        int n;
        loader.wr(8'h0b, 8'h04);
        loader.wr(8'h10, 8'h03);
        @(posedge clock);
        power_req <= 4'h3;
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (power_good[0] !== 1'b1 && n < 40);
        if (n >= 40) begin
            n_errors++;
            $display("BAD power_good expected 1 seen timeout");
            close_out();
        end
        chk("pg_early", 16'h1, {15'h0, n >= 3 * UNITS});
        chk("pg_late", 16'h1, {15'h0, n <= 3 * UNITS + 4});
        repeat (4) @(posedge clock);
        #1;
        chk("pg_disabled", 16'h0, {12'h0, power_good & 4'h2});
        @(posedge clock);
        power_req <= 4'h0;
        settle();
        chk("pg_drop", 16'h0, {12'h0, power_good});
        loader.wr(8'h10, 8'h00);
        @(posedge clock);
        power_req <= 4'h1;
        repeat (2) @(posedge clock);
        #1;
        chk("pg_zero", 16'h1, {15'h0, power_good[0]});
        @(posedge clock);
        power_req <= 4'h0;
        settle();
        $display("END power good");
    endtask : t_power_good

    initial begin
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        #1;
        t_reset_values();
        t_mask();
        t_straps();
        t_power();
        t_strings();
        t_power_good();
        close_out();
    end
endmodule : hub_port_power_config_regs_bench
